// file: bench/keyed_window_watchdog_bench.sv
/*
 * Self-checking bench for the keyed window watchdog, acting as the APB
 * software side. Assumes rc_osc_model as oscillator and fault collector.
 */
`default_nettype none

module keyed_window_watchdog_bench import watchdog_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, fault, osc, fault_seen;
    logic run = 1'b0;
    logic clr = 1'b1;
    logic [15:0] edges;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int compares = 0;

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    keyed_window_watchdog i_dut (.core_clk_i(core_clk), .reset_n_i(reset_n),
        .internal_rc_oscillator_i(osc), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .fault_collector_o(fault));

    rc_osc_model #(.HALF(4)) i_far (.core_clk_i(core_clk), .run_i(run), .clr_i(clr),
        .fault_i(fault), .osc_o(osc), .edges_o(edges), .fault_seen_o(fault_seen));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic guard(input int k);
        if (k >= 900) begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 900);
        guard(k);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        xfer(1'b1, addr, data);
    endtask

    task automatic rdc(input logic [11:0] addr, input logic [31:0] exp);
        xfer(1'b0, addr, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic do_reset();
        reset_n <= 1'b0;
        clr <= 1'b1;
        run <= 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        clr <= 1'b0;
        @(posedge core_clk);
    endtask

    // runs the oscillator up to a total edge count since reset
    task automatic run_ticks(input int n);
        int k;
        run <= 1'b1;
        k = 0;
        while (edges < 16'(n) && k < 900) begin
            @(posedge core_clk);
            k++;
        end
        run <= 1'b0;
        guard(k);
        repeat (6) @(posedge core_clk);
    endtask

    // runs the oscillator until fault (pick=1) or irq rises
    task automatic wait_out(input logic pick, input int ticks);
        int k;
        run <= 1'b1;
        k = 0;
        while ((pick ? fault : irq) !== 1'b1 && k < 900) begin
            @(posedge core_clk);
            k++;
        end
        run <= 1'b0;
        guard(k);
        check({16'h0000, edges}, 32'(ticks));
    endtask

    function automatic logic [15:0] step(input logic [15:0] k);
        return (k + 16'h0003) * 16'h0011;
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        do_reset();
        rdc(ADDR_CTRL, 32'h0000_0000);
        rdc(ADDR_TIMEOUT, 32'h0000_FFFF);
        rdc(ADDR_COUNT, 32'h0000_FFFF);
        rdc(ADDR_KEY, 32'h0000_0000);
        xfer(1'b1, 12'h020, 32'h0000_0001);
        check({31'h0, err}, 32'h0000_0001);
        $display("test reset done");
    endtask

    task automatic t_fixed();
        do_reset();
        wr(ADDR_TIMEOUT, 32'h0000_0014);
        wr(ADDR_CTRL, 32'h0000_0001);
        run_ticks(5);
        rdc(ADDR_COUNT, 32'h0000_000F);
        wr(ADDR_SERVICE, 32'h0000_A602);
        rdc(ADDR_COUNT, 32'h0000_000F);
        wr(ADDR_SERVICE, 32'h0000_B480);
        rdc(ADDR_COUNT, 32'h0000_0014);
        wr(ADDR_SERVICE, 32'h0000_B480);
        rdc(ADDR_STATUS, 32'h0000_0004);
        $display("test fixed done");
    endtask

    task automatic t_keyed();
        logic [15:0] k;
        do_reset();
        wr(ADDR_TIMEOUT, 32'h0000_0014);
        wr(ADDR_CTRL, 32'h0000_0009);
        run_ticks(3);
        k = 16'h0000;
        wr(ADDR_SERVICE, {16'h0000, k});
        k = step(k);
        wr(ADDR_SERVICE, {16'h0000, k});
        rdc(ADDR_COUNT, 32'h0000_0014);
        rdc(ADDR_KEY, {16'h0000, step(k)});
        run_ticks(5);
        wr(ADDR_SERVICE, 32'h0000_1234);
        rdc(ADDR_COUNT, 32'h0000_0012);
        rdc(ADDR_STATUS, 32'h0000_0004);
        $display("test keyed done");
    endtask

    task automatic t_immediate();
        do_reset();
        wr(ADDR_TIMEOUT, 32'h0000_0003);
        wr(ADDR_MASK, 32'h0000_0002);
        wr(ADDR_CTRL, 32'h0000_0001);
        wait_out(1'b1, 4);
        rdc(ADDR_STATUS, 32'h0000_0002);
        check({31'h0, irq}, 32'h0000_0001);
        check({31'h0, fault_seen}, 32'h0000_0001);
        $display("test immediate done");
    endtask

    task automatic t_irq_first();
        do_reset();
        wr(ADDR_TIMEOUT, 32'h0000_0003);
        wr(ADDR_MASK, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0005);
        wait_out(1'b0, 4);
        check({31'h0, fault}, 32'h0000_0000);
        rdc(ADDR_COUNT, 32'h0000_0003);
        wr(ADDR_MASK, 32'h0000_0000);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0000_0000);
        wr(ADDR_MASK, 32'h0000_0001);
        wr(ADDR_STATUS, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0000_0000);
        rdc(ADDR_STATUS, 32'h0000_0000);
        wait_out(1'b1, 8);
        $display("test irq first done");
    endtask

    task automatic t_window();
        do_reset();
        wr(ADDR_TIMEOUT, 32'h0000_000A);
        wr(ADDR_WINDOW, 32'h0000_0002);
        wr(ADDR_CTRL, 32'h0000_0011);
        wr(ADDR_SERVICE, 32'h0000_A602);
        rdc(ADDR_STATUS, 32'h0000_0004);
        run_ticks(8);
        wr(ADDR_SERVICE, 32'h0000_A602);
        wr(ADDR_SERVICE, 32'h0000_B480);
        rdc(ADDR_COUNT, 32'h0000_000A);
        $display("test window done");
    endtask

    task automatic t_lock();
        do_reset();
        wr(ADDR_CTRL, 32'h0000_0003);
        wr(ADDR_TIMEOUT, 32'h0000_0005);
        wr(ADDR_WINDOW, 32'h0000_0005);
        wr(ADDR_CTRL, 32'h0000_0000);
        rdc(ADDR_CTRL, 32'h0000_0003);
        rdc(ADDR_TIMEOUT, 32'h0000_FFFF);
        rdc(ADDR_WINDOW, 32'h0000_0000);
        $display("test lock done");
    endtask

    initial begin
        @(posedge core_clk);
        t_reset();
        t_fixed();
        t_keyed();
        t_immediate();
        t_irq_first();
        t_window();
        t_lock();
        wrap_up();
    end
endmodule

`default_nettype wire

// file: bench/rc_osc_model.sv
/*
 * Far side of the watchdog: the RC oscillator and a fault collector latch.
 * Assumes the bench starts and stops the oscillator through run_i.
 */
`default_nettype none

module rc_osc_model #(
    parameter int HALF = 4
) (
    // core clock and control
    input wire logic core_clk_i,
    input wire logic run_i,
    input wire logic clr_i,
    // oscillator and fault collector
    input wire logic fault_i,
    output logic osc_o,
    output logic [15:0] edges_o,
    output logic fault_seen_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // oscillator, counted in rising edges
    // ------------------------------------------------------------
    int phase;

    always @(posedge core_clk_i) begin
        if (clr_i) begin
            osc_o <= 1'b0;
            edges_o <= 16'h0000;
            phase <= 0;
        end else if (run_i) begin
            if (phase == HALF - 1) begin
                phase <= 0;
                osc_o <= !osc_o;
                if (!osc_o) begin
                    edges_o <= edges_o + 16'h0001;
                end
            end else begin
                phase <= phase + 1;
            end
        end
    end

    // fault collector keeps what it saw until cleared
    always @(posedge core_clk_i) begin
        if (clr_i) begin
            fault_seen_o <= 1'b0;
        end else if (fault_i === 1'b1) begin
            fault_seen_o <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// file: hw/keyed_window_watchdog.sv
/*
 * Keyed window watchdog with an APB register file, fixed or keyed service,
 * interrupt-first or immediate fault reaction, and a sticky fault output.
 * Assumes an APB master on core_clk_i and the internal RC oscillator as a
 * free-running pin level on internal_rc_oscillator_i.
 */
`default_nettype none

module keyed_window_watchdog
    import watchdog_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // oscillator
    input wire logic internal_rc_oscillator_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // events
    output logic irq_o,
    output logic fault_collector_o
);

    ctrl_t ctrl_r;
    logic [ST_WIDTH-1:0] status_r;
    logic [ST_WIDTH-1:0] status_nxt;
    logic [ST_WIDTH-1:0] mask_r;
    logic [ST_WIDTH-1:0] events;
    logic [31:0] timeout_value_reg_r;
    logic [31:0] window_r;
    logic [31:0] count_r;
    logic [15:0] service_key_r;
    logic pending_r;
    seq_state_t seq_r;
    logic tick;
    logic wr_en;
    logic setup;
    logic svc_wr;
    logic in_window;
    logic word_good;
    logic refresh;
    logic bad_service;
    logic timeout_ev;
    logic [15:0] svc_word;
    logic [31:0] rd_val;
    logic rd_err;

    // ------------------------------------------------------------
    // oscillator tick
    // ------------------------------------------------------------
    osc_tick_sync u_tick (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .osc_i(internal_rc_oscillator_i),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [11:0] a);
        return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_MASK || a == ADDR_SERVICE ||
               a == ADDR_TIMEOUT || a == ADDR_WINDOW || a == ADDR_COUNT || a == ADDR_KEY;
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
        return a == reg_addr;
    endfunction

    assign setup = psel_i & ~penable_i;
    assign wr_en = psel_i & penable_i & pready_o & pwrite_i & is_mapped(paddr_i);
    assign svc_wr = wr_en & hit(paddr_i, ADDR_SERVICE);
    assign svc_word = pwdata_i[15:0];

    // ------------------------------------------------------------
    // service sequence
    // ------------------------------------------------------------
    assign in_window = ~ctrl_r.window_en || count_r <= window_r;

    always_comb begin
        if (ctrl_r.keyed) begin
            word_good = svc_word == service_key_r;
        end else if (seq_r == SEQ_IDLE) begin
            word_good = svc_word == FIX_WORD_A;
        end else begin
            word_good = svc_word == FIX_WORD_B;
        end
    end

    assign bad_service = svc_wr & ctrl_r.enable & ~(word_good & in_window & ~fault_collector_o);
    assign refresh = svc_wr & ctrl_r.enable & ~bad_service & seq_r == SEQ_HALF;
    assign timeout_ev = tick & ctrl_r.enable & count_r == 32'h0000_0000 & ~refresh & ~fault_collector_o;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seq_r <= SEQ_IDLE;
        end else if (!ctrl_r.enable || bad_service) begin
            seq_r <= SEQ_IDLE;
        end else if (svc_wr) begin
            case (seq_r)
                SEQ_IDLE: seq_r <= SEQ_HALF;
                SEQ_HALF: seq_r <= SEQ_IDLE;
                default: seq_r <= SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            service_key_r <= KEY_RESET;
        end else if (svc_wr && ctrl_r.enable && ctrl_r.keyed && !bad_service) begin
            service_key_r <= key_next(service_key_r);
        end
    end

    // ------------------------------------------------------------
    // down counter and reaction
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_r <= TIMEOUT_RESET;
        end else if (!ctrl_r.enable || refresh) begin
            count_r <= timeout_value_reg_r;
        end else if (timeout_ev && ctrl_r.irq_first && !pending_r) begin
            count_r <= timeout_value_reg_r;
        end else if (tick && count_r != 32'h0000_0000) begin
            count_r <= count_r - 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_r <= 1'b0;
        end else if (!ctrl_r.enable || refresh) begin
            pending_r <= 1'b0;
        end else if (timeout_ev && ctrl_r.irq_first) begin
            pending_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fault_collector_o <= 1'b0;
        end else if (timeout_ev && (!ctrl_r.irq_first || pending_r)) begin
            fault_collector_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r <= CTRL_RESET;
            timeout_value_reg_r <= TIMEOUT_RESET;
            window_r <= WINDOW_RESET;
        end else if (wr_en && !ctrl_r.hard_lock_flag) begin
            if (hit(paddr_i, ADDR_CTRL)) begin
                ctrl_r <= ctrl_t'(pwdata_i[CTRL_WIDTH-1:0]);
            end
            if (hit(paddr_i, ADDR_TIMEOUT)) begin
                timeout_value_reg_r <= pwdata_i;
            end
            if (hit(paddr_i, ADDR_WINDOW)) begin
                window_r <= pwdata_i;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    always_comb begin
        events = '0;
        events[ST_TIMEOUT_BIT] = timeout_ev & ctrl_r.irq_first & ~pending_r;
        events[ST_FAULT_BIT] = timeout_ev & (~ctrl_r.irq_first | pending_r);
        events[ST_INVALID_BIT] = bad_service;
        status_nxt = status_r;
        if (wr_en && hit(paddr_i, ADDR_STATUS)) begin
            status_nxt = status_r & ~pwdata_i[ST_WIDTH-1:0];
        end
        status_nxt = status_nxt | events;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_r <= '0;
            mask_r <= '0;
            irq_o <= 1'b0;
        end else begin
            status_r <= status_nxt;
            if (wr_en && hit(paddr_i, ADDR_MASK)) begin
                mask_r <= pwdata_i[ST_WIDTH-1:0];
                irq_o <= |(status_nxt & pwdata_i[ST_WIDTH-1:0]);
            end else begin
                irq_o <= |(status_nxt & mask_r);
            end
        end
    end

    // ------------------------------------------------------------
    // read path, no wait states
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr_i)
            ADDR_CTRL: rd_val = {{(32-CTRL_WIDTH){1'b0}}, ctrl_r};
            ADDR_STATUS: rd_val = {{(32-ST_WIDTH){1'b0}}, status_r};
            ADDR_MASK: rd_val = {{(32-ST_WIDTH){1'b0}}, mask_r};
            ADDR_SERVICE: rd_val = 32'h0000_0000;
            ADDR_TIMEOUT: rd_val = timeout_value_reg_r;
            ADDR_WINDOW: rd_val = window_r;
            ADDR_COUNT: rd_val = count_r;
            ADDR_KEY: rd_val = {16'h0000, service_key_r};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup & rd_err;
            if (setup && !pwrite_i) begin
                prdata_o <= rd_val;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_second_timeout_fault: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        timeout_ev && ctrl_r.irq_first && pending_r |=> fault_collector_o && status_r[ST_FAULT_BIT])
        else $error("second timeout did not raise fault");

    a_immediate_fault: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        timeout_ev && !ctrl_r.irq_first |=> fault_collector_o)
        else $error("immediate reaction did not raise fault");

    a_irq_first_reload: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        timeout_ev && ctrl_r.irq_first && !pending_r
        |=> !fault_collector_o && pending_r && count_r == $past(timeout_value_reg_r) && status_r[ST_TIMEOUT_BIT])
        else $error("first timeout did not reload and flag");

    a_key_step_value: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        svc_wr && ctrl_r.enable && ctrl_r.keyed && !bad_service
        |=> service_key_r == 16'((32'($past(service_key_r)) + 32'd3) * 32'd17))
        else $error("service key step wrong");

    a_lock_holds_config: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ctrl_r.hard_lock_flag |=> $stable(ctrl_r) && $stable(timeout_value_reg_r) && $stable(window_r))
        else $error("locked configuration changed");

    a_count_decrement: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ctrl_r.enable && tick && count_r != 32'h0000_0000 && !refresh && !$changed(ctrl_r)
        |=> count_r == $past(count_r) - 32'h0000_0001)
        else $error("counter did not decrement on tick");

    a_fixed_reload: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        svc_wr && ctrl_r.enable && !ctrl_r.keyed && seq_r == SEQ_HALF && svc_word == FIX_WORD_B
        && in_window && !fault_collector_o |=> count_r == $past(timeout_value_reg_r) && !pending_r)
        else $error("fixed sequence did not reload");

    a_window_reject: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        svc_wr && ctrl_r.enable && !in_window |=> status_r[ST_INVALID_BIT] && seq_r == SEQ_IDLE)
        else $error("service outside window accepted");

    a_irq_level: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (|(status_r & mask_r)) && !wr_en |-> irq_o)
        else $error("interrupt low with unmasked status");

    a_keyed_reload: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        svc_wr && ctrl_r.enable && ctrl_r.keyed && seq_r == SEQ_HALF && svc_word == service_key_r
        && in_window && !fault_collector_o |=> count_r == $past(timeout_value_reg_r) && !pending_r)
        else $error("matching key pair did not reload");

    a_keyed_mismatch: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        svc_wr && ctrl_r.enable && ctrl_r.keyed && svc_word != service_key_r
        |=> status_r[ST_INVALID_BIT] && seq_r == SEQ_IDLE && $stable(service_key_r))
        else $error("wrong key was accepted");

    a_disabled_reload: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !ctrl_r.enable |=> count_r == $past(timeout_value_reg_r) && !pending_r)
        else $error("disabled counter not held at timeout value");

    a_count_needs_tick: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ctrl_r.enable && !tick && !refresh |=> $stable(count_r))
        else $error("counter moved without an oscillator tick");

    a_fault_sticky: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        fault_collector_o |=> fault_collector_o)
        else $error("fault output dropped");

    a_ready_after_setup: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        setup |=> pready_o && pslverr_o == $past(rd_err))
        else $error("no ready after setup cycle");

    a_ready_one_cycle: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        psel_i && penable_i |=> !pready_o)
        else $error("ready held past access cycle");

    a_event_sets_status: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (|events) |=> (status_r & $past(events)) == $past(events))
        else $error("event lost against status clear");

endmodule

`default_nettype wire

// file: hw/osc_tick_sync.sv
/*
 * Brings the internal RC oscillator clock into the core clock domain and
 * turns each of its rising edges into a one-cycle enable pulse.
 * Assumes the oscillator runs well below half the core clock rate.
 */
`default_nettype none

module osc_tick_sync (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // oscillator level and tick
    input wire logic osc_i,
    output logic tick_o
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // ------------------------------------------------------------
    // two-stage synchroniser, then edge detect on the second stage
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            meta_r <= osc_i;
            sync_r <= meta_r;
            last_r <= sync_r;
            tick_o <= sync_r & ~last_r;
        end
    end

endmodule

`default_nettype wire

// file: hw/watchdog_pkg.sv
/*
 * Shared constants and types for the keyed window watchdog: register map,
 * field positions, reset values, service words and the key step function.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
`default_nettype none

package watchdog_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_MASK    = 12'h008;
    localparam logic [11:0] ADDR_SERVICE = 12'h00C;
    localparam logic [11:0] ADDR_TIMEOUT = 12'h010;
    localparam logic [11:0] ADDR_WINDOW  = 12'h014;
    localparam logic [11:0] ADDR_COUNT   = 12'h018;
    localparam logic [11:0] ADDR_KEY     = 12'h01C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT    = 0;
    localparam int CTRL_LOCK_BIT      = 1;
    localparam int CTRL_IRQ_FIRST_BIT = 2;
    localparam int CTRL_KEYED_BIT     = 3;
    localparam int CTRL_WINDOW_BIT    = 4;
    localparam int CTRL_WIDTH         = 5;

    localparam int ST_TIMEOUT_BIT = 0;
    localparam int ST_FAULT_BIT   = 1;
    localparam int ST_INVALID_BIT = 2;
    localparam int ST_WIDTH       = 3;

    // ------------------------------------------------------------
    // reset values and service words
    // ------------------------------------------------------------
    localparam logic [31:0] TIMEOUT_RESET = 32'h0000_FFFF;
    localparam logic [31:0] WINDOW_RESET  = 32'h0000_0000;
    localparam logic [15:0] KEY_RESET     = 16'h0000;
    localparam logic [15:0] FIX_WORD_A    = 16'hA602;
    localparam logic [15:0] FIX_WORD_B    = 16'hB480;
    localparam logic [15:0] KEY_ADD       = 16'h0003;
    localparam logic [15:0] KEY_MUL       = 16'h0011;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic window_en;
        logic keyed;
        logic irq_first;
        logic hard_lock_flag;
        logic enable;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{default: 1'b0};

    typedef enum logic {SEQ_IDLE, SEQ_HALF} seq_state_t;

    // next service key, modulo 2^16 by truncation
    function automatic logic [15:0] key_next(input logic [15:0] key);
        logic [31:0] prod;
        prod = 32'(KEY_MUL) * 32'(key + KEY_ADD);
        return prod[15:0];
    endfunction

endpackage

`default_nettype wire
